// ---- test/snf_converter_model.sv ----
// Model of the ten converters: one ramp sample per channel each period.
// Assumes the filter's resync pulse restarts the sample grid.
`timescale 1ns/1ps
`default_nettype none

module snf_converter_model
  import snf_pkg::*;
#(
  parameter int PERIOD = 1920
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Converter side
  input wire logic converter_resync,
  output logic sample_valid,
  output logic [NUM_CH-1:0][SAMPLE_W-1:0] sample_data
);
  logic run;
  int cnt;
  int k;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run <= 1'b0;
      cnt <= 0;
      k <= 0;
      sample_valid <= 1'b0;
    end else if (converter_resync) begin
      run <= 1'b1;
      cnt <= 0;
      k <= 0;
      sample_valid <= 1'b0;
    end else begin
      sample_valid <= run && cnt == PERIOD - 1;
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      k <= k + int'(sample_valid);
    end
  end

  // Off-strobe the lines show the inverse, so a late read cannot match
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      sample_data[i] = SAMPLE_W'(i * 1000 - 4000 + k) ^ {SAMPLE_W{!sample_valid}};
    end
  end
endmodule // snf_converter_model

`default_nettype wire

// ---- test/snf_sinc_filter_monitor.sv ----
// Checker for the sinc-n filter: start, errors, plan and result hand-off.
// Sees only the top ports; bound to every snf_sinc_filter instance.
`timescale 1ns/1ps
`default_nettype none

module snf_sinc_filter_monitor
  import snf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Scan control and status
  input wire logic scan_start,
  input wire logic [31:0] scan_interval_us,
  input wire logic scan_busy,
  input wire logic config_error,
  input wire logic converter_resync,
  input wire snf_plan_type plan,
  // Results
  input wire logic result_valid,
  input wire logic result_ready,
  input wire snf_result_type result_data
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_accept;
    scan_start && !scan_busy;
  endsequence
  sequence s_launch;
    converter_resync && scan_busy ##1 !converter_resync;
  endsequence

  a_resync_launch: assert property (s_accept |=> s_launch)
    else $error("resync pulse missing after start");
  a_resync_cause: assert property (converter_resync |-> $past(scan_start) && !$past(scan_busy))
    else $error("resync without accepted start");
  a_busy_refused: assert property (scan_start && scan_busy |=> config_error)
    else $error("start while busy not flagged");
  a_error_clear: assert property (s_accept |=> !config_error)
    else $error("error not cleared by start");
  a_error_hold: assert property (config_error && !scan_start |=> config_error)
    else $error("error dropped on its own");
  a_short_scan: assert property (scan_start && !scan_busy && scan_interval_us < 32'h5F0 |-> ##[2:3] config_error)
    else $error("short interval accepted");
  a_plan_count: assert property ($changed(plan) |-> plan.samples_per_scan ==
    (plan.filter_order * (plan.integration_time / (96 * plan.preavg_count) - 1) + 1) * plan.preavg_count)
    else $error("sample count wrong for plan");
  a_plan_order: assert property ($changed(plan) |-> plan.filter_order inside {[1:5]})
    else $error("filter order out of range");
  a_plan_limit: assert property ($changed(plan) && plan.filter_order > 1 && plan.preavg_count == 1
    |-> plan.integration_time / 96 <= 681 / plan.filter_order)
    else $error("integration above order limit");
  a_result_hold: assert property (result_valid && !result_ready |=> result_valid && $stable(result_data))
    else $error("result changed before pop");
endmodule // snf_sinc_filter_monitor

bind snf_sinc_filter snf_sinc_filter_monitor u_monitor (.clk(clk), .arst_n(arst_n), .scan_start(scan_start),
  .scan_interval_us(scan_interval_us), .scan_busy(scan_busy), .config_error(config_error),
  .converter_resync(converter_resync), .plan(plan), .result_valid(result_valid),
  .result_ready(result_ready), .result_data(result_data));

`default_nettype wire

// ---- test/snf_sinc_filter_test.sv ----
// Testbench for the sinc-n filter: rejections, order trim, scans, drain.
// Assumes the converter model drives a ramp from each resync.
`timescale 1ns/1ps
`default_nettype none

module snf_sinc_filter_test;
  import snf_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic scan_start = 1'b0;
  logic open_circuit_check_range = 1'b0;
  logic result_ready = 1'b0;
  logic [31:0] scan_interval_us = 32'h0;
  logic [NUM_CH-1:0][31:0] ch_integ_setting = '0;
  logic [NUM_CH-1:0] ch_input_reversal_flag = '0;
  logic converter_resync, sample_valid, scan_busy, config_error, result_valid;
  logic [NUM_CH-1:0][SAMPLE_W-1:0] sample_data;
  snf_plan_type plan;
  snf_result_type result_data;
  int failures = 0;
  int checks = 0;

  always #25 clk = ~clk;

  snf_sinc_filter DUT (.clk(clk), .arst_n(arst_n), .scan_start(scan_start), .scan_interval_us(scan_interval_us),
    .open_circuit_check_range(open_circuit_check_range), .ch_integ_setting(ch_integ_setting),
    .ch_input_reversal_flag(ch_input_reversal_flag), .converter_resync(converter_resync),
    .sample_valid(sample_valid), .sample_data(sample_data), .scan_busy(scan_busy), .config_error(config_error),
    .plan(plan), .result_valid(result_valid), .result_ready(result_ready), .result_data(result_data));
  snf_converter_model conv (.clk(clk), .arst_n(arst_n), .converter_resync(converter_resync),
    .sample_valid(sample_valid), .sample_data(sample_data));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Sel 0 busy, 1 result valid, 2 plan loaded
  task automatic wait_on(input int sel, input logic lvl, input int lim);
    int n;
    n = 0;
    while ((sel == 0 ? scan_busy : sel == 1 ? result_valid : |plan.filter_order) !== lvl) begin
      if (n == lim) begin
        failures++;
        $display("Error at %0t: wait ran out", $time);
        end_sim;
      end
      n++;
      @(negedge clk);
    end
  endtask

  task automatic start(input int iv, input logic ocr, input logic rev, input int set, input logic odd);
    @(negedge clk);
    scan_interval_us = 32'(iv);
    open_circuit_check_range = ocr;
    ch_integ_setting = {NUM_CH{32'(set)}};
    ch_input_reversal_flag = {NUM_CH{rev}} ^ (NUM_CH'(odd) << 3);
    scan_start = 1'b1;
    @(negedge clk);
    scan_start = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reject;
    int iv[7] = '{1000, 3000, 3000, 4000, 3000, 3000, 3000};
    int st[7] = '{288, 150, 288, -2, -6, 288, 1920};
    int fl[7] = '{0, 0, 4, 2, 0, 1, 0};
    for (int r = 0; r < 7; r++) begin
      start(iv[r], fl[r][2], fl[r][1], st[r], fl[r][0]);
      wait_on(0, 1'b0, 600);
      // Error flag is registered one edge after the sequencer returns to idle
      @(negedge clk);
      chk(config_error, 1);
    end
    $display("reject done");
  endtask

  task automatic test_trim;
    start(70000, 1'b0, 1'b0, 32736, 1'b0);
    wait_on(2, 1'b1, 1000);
    chk(plan.filter_order, 1);
    chk(plan.samples_per_scan, 341);
    arst_n = 1'b0;
    @(negedge clk);
    chk(scan_busy, 0);
    chk(plan.integration_time, 0);
    arst_n = 1'b1;
    $display("trim done");
  endtask

  task automatic run_scan(input int iv, input int set, input int ord, input int integ, input int s, input logic dbl);
    int b;
    start(iv, 1'b0, 1'b0, set, 1'b0);
    if (dbl) start(iv, 1'b0, 1'b0, set, 1'b0);
    wait_on(1, 1'b1, 30000);
    chk(plan.filter_order, ord);
    chk(plan.preavg_count, 1);
    chk(plan.integration_time, integ);
    chk(plan.samples_per_scan, s);
    // Reader stalls so the result buffer fills and holds the scan open
    if (dbl) repeat (800) @(negedge clk);
    chk(scan_busy, 1);
    for (int i = 0; i < NUM_CH; i++) begin
      wait_on(1, 1'b1, 3000);
      b = i * 1000 - 4000;
      chk(32'(result_data.channel), i);
      chk(result_data.value, 32'((2 * b + s - 1) / 2));
      result_ready = 1'b1;
      @(negedge clk);
      result_ready = 1'b0;
    end
    wait_on(0, 1'b0, 300);
    chk(config_error, dbl);
    $display("scan %0d done", set);
  endtask

  initial begin
    int m;
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    test_reject();
    test_trim();
    run_scan(3000, 288, 5, 288, 11, 1'b1);
    for (int k = 1; k <= 5; k++) begin
      m = (680 / 96 - 1) / k + 1;
      run_scan(2000, -k, k, m * 96, k * (m - 1) + 1, 1'b0);
    end
    end_sim();
  end
endmodule // snf_sinc_filter_test

`default_nettype wire

// ---- verilog/snf_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; full and empty follow an occupancy count.
`timescale 1ns/1ps
`default_nettype none

module snf_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // snf_fifo

`default_nettype wire

// ---- verilog/snf_pkg.sv ----
// Constants, states and carrier types for the sinc-n integration filter.
// Assumes times are whole microseconds and one module clock.
`default_nettype none

package snf_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH = 10;
  localparam int SAMPLE_W = 24;
  localparam int ACC_W = 64;
  localparam int RES_W = 32;
  localparam int MAX_ORDER = 5;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // Timing figures in microseconds
  // ----------------------------------------------------------------
  localparam int SAMPLE_PERIOD_US = 96;
  localparam int OVERHEAD_US = 1320;
  localparam int OPEN_CHECK_US = 1520;
  localparam int REVERSAL_US = 420;
  localparam int MIN_INTEG_US = 192;
  localparam int MIN_SCAN_US = 1520;
  localparam int MIN_AVAIL_US = 200;

  // ----------------------------------------------------------------
  // Filter limits
  // ----------------------------------------------------------------
  localparam int MAX_SAMPLES = 680;

  typedef enum logic [2:0] {
    SNF_IDLE    = 3'h0,
    SNF_PLAN    = 3'h1,
    SNF_GAIN    = 3'h3,
    SNF_COLLECT = 3'h2,
    SNF_DRAIN   = 3'h6
  } snf_state_type;

  typedef enum logic [2:0] {
    STEP_AVAIL   = 3'h0,
    STEP_ORDER   = 3'h1,
    STEP_MAUTO   = 3'h3,
    STEP_TRIM    = 3'h2,
    STEP_A96     = 3'h6,
    STEP_NPRE    = 3'h7,
    STEP_QUOT    = 3'h5,
    STEP_MFORCED = 3'h4
  } snf_step_type;

  typedef struct packed {
    logic [2:0] filter_order;
    logic [31:0] preavg_count;
    logic [31:0] integration_time;
    logic [31:0] samples_per_scan;
  } snf_plan_type;

  typedef struct packed {
    logic [3:0] channel;
    logic signed [RES_W-1:0] value;
  } snf_result_type;

endpackage

`default_nettype wire

// ---- verilog/snf_sinc_filter.sv ----
// Per-scan sinc-n planner and decimating filter for ten converter channels.
// Assumes samples arrive as one strobe per 96 us for all channels at once,
// and that the host holds its settings stable from scan start to scan end.
`timescale 1ns/1ps
`default_nettype none

module snf_sinc_filter
  import snf_pkg::*;
#(
  parameter int RESULT_DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Scan control from host
  input wire logic scan_start,
  input wire logic [31:0] scan_interval_us,
  input wire logic open_circuit_check_range,
  // Per-channel instruction settings
  input wire logic [NUM_CH-1:0][31:0] ch_integ_setting,
  input wire logic [NUM_CH-1:0] ch_input_reversal_flag,
  // Converters
  output logic converter_resync,
  input wire logic sample_valid,
  input wire logic [NUM_CH-1:0][SAMPLE_W-1:0] sample_data,
  // Status
  output logic scan_busy,
  output logic config_error,
  output snf_plan_type plan,
  // Results
  output logic result_valid,
  input wire logic result_ready,
  output snf_result_type result_data
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [39:0] max_integ(input logic [2:0] k);
    max_integ = 40'((MAX_SAMPLES + 1) / int'(k)) * 40'(SAMPLE_PERIOD_US);
  endfunction

  function automatic logic [31:0] mod_small(input logic [2:0] k, input logic [31:0] m);
    logic [31:0] r;
    r = 32'(k);
    for (int j = 0; j < 3; j++) begin
      if (r >= m) r = r - m;
    end
    mod_small = r;
  endfunction

  function automatic logic signed [ACC_W-1:0] binom(input logic [2:0] k, input int i);
    logic signed [ACC_W-1:0] c;
    c = 64'sh1;
    for (int j = 0; j < MAX_ORDER; j++) begin
      if (j < i) c = (c * ACC_W'(int'(k) - j)) / ACC_W'(j + 1);
    end
    binom = c;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  snf_state_type state;
  snf_step_type step;
  logic signed [33:0] avail;
  logic signed [33:0] next_avail;
  logic [31:0] integ_req;
  logic forced_mode;
  logic [2:0] order;
  logic [31:0] n_pre;
  logic [31:0] m_len;
  logic [31:0] s_len;
  logic [63:0] gain;
  logic [2:0] gcnt;
  logic [31:0] ph;
  logic [31:0] pre_cnt;
  logic [31:0] cic_cnt;
  logic [3:0] drain_ch;
  logic drain_div;
  logic reject;
  logic push_valid;
  logic push_ready;
  snf_result_type push_data;
  logic signed [ACC_W-1:0] chan_sum [NUM_CH];

  // Shared serial divider, used by planning and by result scaling
  logic dv_go;
  logic dv_busy;
  logic dv_done;
  logic [63:0] ld_num;
  logic [63:0] ld_den;
  logic [63:0] dv_num;
  logic [63:0] dv_den;
  logic [63:0] dv_rem;
  logic [63:0] dv_quo;
  logic [63:0] dv_trial;
  logic [6:0] dv_cnt;

  // ----------------------------------------------------------------
  // Setting checks and available time
  // ----------------------------------------------------------------
  logic signed [31:0] setting;
  logic mismatch;
  logic forced;
  logic [2:0] forced_order;
  logic scan_accept;
  logic overrun;

  always_comb begin
    setting = $signed(ch_integ_setting[0]);
    mismatch = 1'b0;
    for (int i = 1; i < NUM_CH; i++) begin
      if (ch_integ_setting[i] != ch_integ_setting[0] ||
          ch_input_reversal_flag[i] != ch_input_reversal_flag[0]) mismatch = 1'b1;
    end
    forced = (setting < 0) && (setting >= -32'sd5);
    forced_order = 3'(-setting);
    next_avail = $signed({2'b00, scan_interval_us});
    if (open_circuit_check_range) next_avail = next_avail - 34'(OPEN_CHECK_US);
    if (ch_input_reversal_flag[0]) next_avail = (next_avail >>> 1) - 34'(REVERSAL_US);
    next_avail = next_avail - 34'(OVERHEAD_US);
  end

  assign scan_accept = (state == SNF_IDLE) && scan_start;
  assign overrun = (state != SNF_IDLE) && scan_start;
  assign scan_busy = (state != SNF_IDLE);

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  assign dv_trial = {dv_rem[62:0], dv_num[63]};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dv_num <= '0;
      dv_den <= '0;
      dv_rem <= '0;
      dv_quo <= '0;
      dv_cnt <= '0;
      dv_busy <= 1'b0;
      dv_done <= 1'b0;
    end else if (dv_go) begin
      dv_num <= ld_num;
      dv_den <= ld_den;
      dv_rem <= '0;
      dv_quo <= '0;
      dv_cnt <= 7'h40;
      dv_busy <= 1'b1;
      dv_done <= 1'b0;
    end else if (dv_busy) begin
      dv_rem <= (dv_trial >= dv_den) ? dv_trial - dv_den : dv_trial;
      dv_quo <= {dv_quo[62:0], dv_trial >= dv_den};
      dv_num <= {dv_num[62:0], 1'b0};
      dv_cnt <= dv_cnt - 1'b1;
      dv_busy <= (dv_cnt != 7'h01);
      dv_done <= (dv_cnt == 7'h01);
    end else begin
      dv_done <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Channel datapath: pre-average, integrators, decimated comb
  // ----------------------------------------------------------------
  logic smp_take;
  logic pre_last;
  logic feed;
  logic decim;
  logic last_feed;

  assign smp_take = (state == SNF_COLLECT) && sample_valid;
  assign pre_last = (pre_cnt == n_pre - 1'b1);
  assign feed = smp_take && pre_last;
  assign decim = feed && (ph == '0);
  assign last_feed = feed && (cic_cnt == s_len - 1'b1);

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    logic signed [ACC_W-1:0] pre_sum;
    logic signed [ACC_W-1:0] feed_val;
    logic signed [ACC_W-1:0] comb_val;
    logic signed [ACC_W-1:0] integ [MAX_ORDER];
    logic signed [ACC_W-1:0] nxt [MAX_ORDER];
    logic signed [ACC_W-1:0] hist [MAX_ORDER];

    always_comb begin
      feed_val = pre_sum + $signed({{(ACC_W-SAMPLE_W){sample_data[g][SAMPLE_W-1]}}, sample_data[g]});
      nxt[0] = integ[0] + feed_val;
      for (int j = 1; j < MAX_ORDER; j++) begin
        nxt[j] = integ[j] + nxt[j-1];
      end
      comb_val = nxt[3'(order - 1'b1)];
      for (int i = 1; i <= MAX_ORDER; i++) begin
        if (i <= int'(order)) begin
          if (i % 2 == 1) comb_val = comb_val - binom(order, i) * hist[i-1];
          else comb_val = comb_val + binom(order, i) * hist[i-1];
        end
      end
    end

    // Integrators may wrap; the comb difference stays exact modulo 2^64
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        pre_sum <= '0;
        chan_sum[g] <= '0;
        for (int j = 0; j < MAX_ORDER; j++) begin
          integ[j] <= '0;
          hist[j] <= '0;
        end
      end else if (scan_accept) begin
        pre_sum <= '0;
        for (int j = 0; j < MAX_ORDER; j++) begin
          integ[j] <= '0;
          hist[j] <= '0;
        end
      end else if (smp_take) begin
        pre_sum <= pre_last ? '0 : feed_val;
        if (feed) begin
          for (int j = 0; j < MAX_ORDER; j++) integ[j] <= nxt[j];
        end
        if (decim) begin
          hist[0] <= nxt[3'(order - 1'b1)];
          for (int j = 1; j < MAX_ORDER; j++) hist[j] <= hist[j-1];
        end
        if (last_feed) chan_sum[g] <= comb_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // Resync and error flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      converter_resync <= 1'b0;
    end else begin
      converter_resync <= scan_accept;
    end
  end

  // Set wins over the clear of a new scan
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      config_error <= 1'b0;
    end else if (reject || overrun) begin
      config_error <= 1'b1;
    end else if (scan_accept) begin
      config_error <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer: plan, gain, collect, drain
  // ----------------------------------------------------------------
  logic signed [ACC_W-1:0] drain_y;
  logic [63:0] drain_q;

  assign drain_y = chan_sum[drain_ch];
  assign drain_q = dv_quo;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= SNF_IDLE;
      step <= STEP_AVAIL;
      avail <= '0;
      integ_req <= '0;
      forced_mode <= 1'b0;
      order <= 3'h1;
      n_pre <= 32'h1;
      m_len <= 32'h2;
      s_len <= 32'h2;
      gain <= 64'h1;
      gcnt <= '0;
      ph <= '0;
      pre_cnt <= '0;
      cic_cnt <= '0;
      drain_ch <= '0;
      drain_div <= 1'b0;
      reject <= 1'b0;
      push_valid <= 1'b0;
      push_data <= '0;
      plan <= '0;
      dv_go <= 1'b0;
      ld_num <= '0;
      ld_den <= 64'h1;
    end else begin
      dv_go <= 1'b0;
      reject <= 1'b0;
      case (state)
        SNF_IDLE: begin
          if (scan_start) begin
            state <= SNF_PLAN;
            step <= STEP_AVAIL;
          end
        end
        SNF_PLAN: begin
          case (step)
            STEP_AVAIL: begin
              avail <= next_avail;
              integ_req <= setting;
              forced_mode <= forced;
              if (mismatch || scan_interval_us < 32'(MIN_SCAN_US)) begin
                reject <= 1'b1;
                state <= SNF_IDLE;
              end else if (forced) begin
                order <= forced_order;
                if (next_avail < 34'((int'(forced_order) + 1) * SAMPLE_PERIOD_US)) begin
                  reject <= 1'b1;
                  state <= SNF_IDLE;
                end else begin
                  ld_num <= 64'(next_avail);
                  ld_den <= 64'(SAMPLE_PERIOD_US);
                  dv_go <= 1'b1;
                  step <= STEP_A96;
                end
              end else if (setting >= 32'sd192 && next_avail >= 34'(MIN_AVAIL_US)) begin
                ld_num <= 64'(next_avail - 34'(SAMPLE_PERIOD_US));
                ld_den <= 64'(setting - 32'(SAMPLE_PERIOD_US));
                dv_go <= 1'b1;
                step <= STEP_ORDER;
              end else begin
                reject <= 1'b1;
                state <= SNF_IDLE;
              end
            end
            STEP_ORDER: begin
              if (dv_done) begin
                if (dv_quo == '0) begin
                  reject <= 1'b1;
                  state <= SNF_IDLE;
                end else begin
                  order <= (dv_quo > 64'(MAX_ORDER)) ? 3'(MAX_ORDER) : dv_quo[2:0];
                  ld_num <= 64'(integ_req);
                  ld_den <= 64'(SAMPLE_PERIOD_US);
                  dv_go <= 1'b1;
                  step <= STEP_MAUTO;
                end
              end
            end
            STEP_MAUTO: begin
              if (dv_done) begin
                m_len <= dv_quo[31:0];
                n_pre <= 32'h1;
                step <= STEP_TRIM;
              end
            end
            STEP_TRIM: begin
              if (!forced_mode && order > 3'h1 && 40'(m_len) * 40'(SAMPLE_PERIOD_US) > max_integ(order)) begin
                order <= order - 1'b1;
              end else begin
                s_len <= 32'(order * (m_len - 1'b1) + 1'b1);
                gain <= 64'(n_pre);
                gcnt <= order;
                state <= SNF_GAIN;
              end
            end
            STEP_A96: begin
              if (dv_done) begin
                ld_num <= dv_quo - 1'b1;
                ld_den <= 64'(MAX_SAMPLES);
                dv_go <= 1'b1;
                step <= STEP_NPRE;
              end
            end
            STEP_NPRE: begin
              if (dv_done) begin
                n_pre <= 32'(dv_quo + 1'b1);
                ld_num <= 64'(avail);
                ld_den <= 64'(32'(dv_quo + 1'b1) * 64'(SAMPLE_PERIOD_US));
                dv_go <= 1'b1;
                step <= STEP_QUOT;
              end
            end
            STEP_QUOT: begin
              if (dv_done) begin
                if (dv_quo == '0) begin
                  reject <= 1'b1;
                  state <= SNF_IDLE;
                end else begin
                  ld_num <= dv_quo - 1'b1;
                  ld_den <= 64'(order);
                  dv_go <= 1'b1;
                  step <= STEP_MFORCED;
                end
              end
            end
            STEP_MFORCED: begin
              if (dv_done) begin
                m_len <= 32'(dv_quo + 1'b1);
                step <= STEP_TRIM;
              end
            end
            default: begin
              state <= SNF_IDLE;
            end
          endcase
        end
        SNF_GAIN: begin
          if (gcnt != '0) begin
            gain <= 64'(gain * 64'(m_len));
            gcnt <= gcnt - 1'b1;
          end else begin
            plan.filter_order <= order;
            plan.preavg_count <= n_pre;
            plan.integration_time <= 32'(m_len * 32'(SAMPLE_PERIOD_US) * n_pre);
            plan.samples_per_scan <= 32'(s_len * n_pre);
            ph <= mod_small(order, m_len);
            pre_cnt <= '0;
            cic_cnt <= '0;
            state <= SNF_COLLECT;
          end
        end
        SNF_COLLECT: begin
          if (smp_take) begin
            pre_cnt <= pre_last ? '0 : pre_cnt + 1'b1;
          end
          if (feed) begin
            cic_cnt <= cic_cnt + 1'b1;
            ph <= (ph == m_len - 1'b1) ? '0 : ph + 1'b1;
          end
          if (last_feed) begin
            drain_ch <= '0;
            drain_div <= 1'b0;
            state <= SNF_DRAIN;
          end
        end
        SNF_DRAIN: begin
          // Divide by N * M^order to turn the weighted sum into a mean
          if (!drain_div) begin
            ld_num <= drain_y[ACC_W-1] ? 64'(-drain_y) : 64'(drain_y);
            ld_den <= gain;
            dv_go <= 1'b1;
            drain_div <= 1'b1;
          end else if (dv_done) begin
            push_valid <= 1'b1;
            push_data.channel <= drain_ch;
            push_data.value <= drain_y[ACC_W-1] ? -$signed(drain_q[RES_W-1:0]) : $signed(drain_q[RES_W-1:0]);
          end else if (push_valid && push_ready) begin
            push_valid <= 1'b0;
            drain_div <= 1'b0;
            if (drain_ch == 4'(NUM_CH - 1)) begin
              state <= SNF_IDLE;
            end else begin
              drain_ch <= drain_ch + 1'b1;
            end
          end
        end
        default: begin
          state <= SNF_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Result buffer; a stalled reader holds the drain
  // ----------------------------------------------------------------
  snf_fifo #(
    .WIDTH($bits(snf_result_type)),
    .DEPTH(RESULT_DEPTH)
  ) u_result_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(result_valid),
    .out_ready(result_ready),
    .out_data(result_data)
  );

endmodule // snf_sinc_filter

`default_nettype wire
